// file: logic/hrp_dev_port.sv
/*
 Device end: serial slave port giving access to byte registers.
 Link logic runs on link_clk, which oversamples the lines; register
 strobes leave on ref_clk through a toggle handshake. Assumes the
 register side answers reads in the strobe cycle.
*/
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// R01: data falling while clock high starts access
// R02: data rising while clock high stops access
// R03: eight data bits then one acknowledge bit
// R04: matching address acknowledged low in ninth period
// R05: subaddress and written data bytes acknowledged
// R06: subaddress increments after every data byte
// R07: transmitter releases data during acknowledge period
// R08: master ends read with no-ack, stop
// R09: first byte: seven address bits, direction
// R10: answers 0x74/0x76 write, 0x75/0x77 read
// R11: read without subaddress starts at 0x08
// R12: start, address, subaddress, data, stop order
// R13: random read via repeated start, ack except last
module hrp_dev_port
    import hrp_pkg::*;
(
    // link side
    input wire logic link_clk,
    hrp_link_if.dev link,
    // system side
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic addr_sel,
    // register port
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata,
    output logic reg_wr_stb,
    output logic reg_rd_stb,
    input wire logic [7:0] reg_rdata
);
    // ----------------------------------------
    // states
    // ----------------------------------------
    typedef enum logic [4:0] {
        D_IDLE = 5'b00001,
        D_ADDR = 5'b00010,
        D_SUB = 5'b00100,
        D_WDATA = 5'b01000,
        D_RDATA = 5'b10000
    } hrp_dst_t;

    // link domain state
    logic lrst_s1_q, lrst_s2_q;      // reset brought onto link_clk
    logic scl_s1_q, scl_s2_q, scl_p_q;
    logic sda_s1_q, sda_s2_q, sda_p_q;
    logic sel_s1_q, sel_s2_q;
    hrp_dst_t st_q;
    logic [3:0] cnt_q;                // clock rises within a byte
    logic [7:0] shift_q;              // received bits
    logic [7:0] tx_q;                 // byte being sent
    logic [7:0] sub_q;                // register subaddress
    logic sub_ok_q;                   // subaddress given this access
    logic hit_q;                      // address matched
    logic nack_q;                     // master did not acknowledge
    logic sda_oe_q;
    logic req_tgl_q, req_wr_q;
    logic [7:0] req_addr_q, req_data_q;
    logic ack_s1_q, ack_s2_q, ack_s3_q;
    // ref domain state
    logic rq_s1_q, rq_s2_q, rq_s3_q;
    logic ack_tgl_q;
    logic [7:0] rd_hold_q;            // read byte, stable across crossing
    logic [7:0] reg_addr_q, reg_wdata_q;
    logic reg_wr_q, reg_rd_q;

    // ----------------------------------------
    // decode
    // ----------------------------------------
    wire lrst = lrst_s2_q;
    wire scl_rise = scl_s2_q & ~scl_p_q;
    wire scl_fall = ~scl_s2_q & scl_p_q;
    wire start_cond = scl_s2_q & scl_p_q & sda_p_q & ~sda_s2_q; // R01
    wire stop_cond = scl_s2_q & scl_p_q & ~sda_p_q & sda_s2_q;  // R02
    wire [6:0] my_addr = sel_s2_q ? ADDR7_SEL1 : ADDR7_SEL0;   // R10
    wire addr_hit = (shift_q[7:1] == my_addr);                 // R09
    wire is_read = shift_q[0];
    wire [7:0] first_sub = sub_ok_q ? sub_q : SUB_LINK_INTEGRITY; // R11
    wire [2:0] tx_idx = 3'(BIT_LAST_DATA - cnt_q);
    wire ack_edge = ack_s2_q ^ ack_s3_q;
    wire rq_edge = rq_s2_q ^ rq_s3_q;

    assign link.s_sda_o = 1'b0;
    assign link.s_sda_oe = sda_oe_q;
    assign reg_addr = reg_addr_q;
    assign reg_wdata = reg_wdata_q;
    assign reg_wr_stb = reg_wr_q;
    assign reg_rd_stb = reg_rd_q;

    // ----------------------------------------
    // link domain synchronisers
    // ----------------------------------------
    // reset is sampled twice; its first stage feeds only the second
    always_ff @(posedge link_clk)
    begin
        lrst_s1_q <= sys_rst;
        lrst_s2_q <= lrst_s1_q;
    end

    // lines idle high; the previous sample feeds edge detection
    always_ff @(posedge link_clk)
    begin
        if (lrst)
        begin
            {scl_s1_q, scl_s2_q, scl_p_q} <= 3'h7;
            {sda_s1_q, sda_s2_q, sda_p_q} <= 3'h7;
            {sel_s1_q, sel_s2_q} <= 2'h0;
            {ack_s1_q, ack_s2_q, ack_s3_q} <= 3'h0;
        end
        else
        begin
            {scl_s1_q, scl_s2_q, scl_p_q} <= {link.scl, scl_s1_q, scl_s2_q};
            {sda_s1_q, sda_s2_q, sda_p_q} <= {link.sda, sda_s1_q, sda_s2_q};
            {sel_s1_q, sel_s2_q} <= {addr_sel, sel_s1_q};
            {ack_s1_q, ack_s2_q, ack_s3_q} <= {ack_tgl_q, ack_s1_q, ack_s2_q};
        end
    end

    // read byte lands when the system side answers
    always_ff @(posedge link_clk)
    begin
        if (lrst)
            tx_q <= BYTE_RST;
        else if (ack_edge && !req_wr_q)
            tx_q <= rd_hold_q;
    end

    // ----------------------------------------
    // serial state machine
    // ----------------------------------------
    // start and stop win over bit activity in the same sample
    always_ff @(posedge link_clk)
    begin
        if (lrst)
        begin
            st_q <= D_IDLE;
            cnt_q <= BIT_FIRST;
            shift_q <= BYTE_RST;
            sub_q <= BYTE_RST;
            sub_ok_q <= 1'b0;
            hit_q <= 1'b0;
            nack_q <= 1'b0;
            sda_oe_q <= 1'b0;
            req_tgl_q <= 1'b0;
            req_wr_q <= 1'b0;
            req_addr_q <= BYTE_RST;
            req_data_q <= BYTE_RST;
        end
        else if (start_cond)
        begin
            // a repeated start keeps the subaddress
            st_q <= D_ADDR; // R01 R13
            cnt_q <= BIT_FIRST;
            sda_oe_q <= 1'b0;
        end
        else if (stop_cond)
        begin
            st_q <= D_IDLE; // R02 R12
            cnt_q <= BIT_FIRST;
            sda_oe_q <= 1'b0;
            sub_ok_q <= 1'b0;
        end
        else if (st_q != D_IDLE)
        begin
            if (scl_rise)
            begin
                // sample the eight data bits only
                if (cnt_q < BIT_ACK)
                    shift_q <= {shift_q[6:0], sda_s2_q}; // R03
                cnt_q <= cnt_q + 4'h1;
                if (st_q == D_RDATA && cnt_q == BIT_ACK)
                begin
                    sub_q <= sub_q + 8'h01; // R06
                    nack_q <= sda_s2_q;     // R08
                    // fetch the next byte only if the master wants it
                    if (!sda_s2_q)
                    begin
                        req_tgl_q <= ~req_tgl_q;
                        req_wr_q <= 1'b0;
                        req_addr_q <= sub_q + 8'h01;
                    end
                end
            end
            if (scl_fall && cnt_q == BIT_ACK)
            begin
                // acknowledge slot opens
                unique case (st_q)
                    D_ADDR:
                    begin
                        hit_q <= addr_hit;
                        sda_oe_q <= addr_hit; // R04
                        if (addr_hit && is_read)
                        begin
                            sub_q <= first_sub; // R11
                            req_tgl_q <= ~req_tgl_q;
                            req_wr_q <= 1'b0;
                            req_addr_q <= first_sub;
                        end
                    end
                    D_SUB:
                    begin
                        sda_oe_q <= 1'b1; // R05
                        sub_q <= shift_q;
                        sub_ok_q <= 1'b1;
                    end
                    D_WDATA:
                    begin
                        sda_oe_q <= 1'b1; // R05
                        sub_q <= sub_q + 8'h01; // R06
                        req_tgl_q <= ~req_tgl_q;
                        req_wr_q <= 1'b1;
                        req_addr_q <= sub_q;
                        req_data_q <= shift_q;
                    end
                    D_RDATA:
                        sda_oe_q <= 1'b0; // R07
                    D_IDLE:
                        sda_oe_q <= 1'b0;
                endcase
            end
            else if (scl_fall && cnt_q == BIT_END)
            begin
                // acknowledge slot closes, next byte begins
                cnt_q <= BIT_FIRST;
                sda_oe_q <= 1'b0;
                unique case (st_q)
                    D_ADDR:
                    begin
                        if (!hit_q)
                            st_q <= D_IDLE;
                        else if (is_read)
                        begin
                            st_q <= D_RDATA;
                            sda_oe_q <= ~tx_q[7];
                        end
                        else
                            st_q <= D_SUB; // R12
                    end
                    D_SUB:
                        st_q <= D_WDATA;
                    D_WDATA:
                        st_q <= D_WDATA;
                    D_RDATA:
                    begin
                        // no-ack ends the read; the line stays free
                        if (nack_q)
                            st_q <= D_IDLE; // R08
                        else
                            sda_oe_q <= ~tx_q[7];
                    end
                    D_IDLE:
                        st_q <= D_IDLE;
                endcase
            end
            else if (scl_fall && st_q == D_RDATA && cnt_q < BIT_ACK)
                sda_oe_q <= ~tx_q[tx_idx];
        end
    end

    // ----------------------------------------
    // ref domain side of the handshake
    // ----------------------------------------
    // request fields move with the toggle and stay stable for a byte time after it moves
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            {rq_s1_q, rq_s2_q, rq_s3_q} <= 3'h0;
            ack_tgl_q <= 1'b0;
            rd_hold_q <= BYTE_RST;
            reg_addr_q <= BYTE_RST;
            reg_wdata_q <= BYTE_RST;
            reg_wr_q <= 1'b0;
            reg_rd_q <= 1'b0;
        end
        else
        begin
            {rq_s1_q, rq_s2_q, rq_s3_q} <= {req_tgl_q, rq_s1_q, rq_s2_q};
            reg_wr_q <= rq_edge & req_wr_q;
            reg_rd_q <= rq_edge & ~req_wr_q;
            if (rq_edge)
            begin
                reg_addr_q <= req_addr_q;
                reg_wdata_q <= req_data_q;
            end
            if (reg_rd_q)
                rd_hold_q <= reg_rdata;
            if (reg_rd_q || reg_wr_q)
                ack_tgl_q <= ~ack_tgl_q;
        end
    end
endmodule : hrp_dev_port
`default_nettype wire

// file: logic/hrp_host_port.sv
/*
 Host end: serial bus master that drives the display channel.
 The serial clock is divided from ref_clk; no clock stretching.
*/
`timescale 1ns/1ps
`default_nettype none
module hrp_host_port
    import hrp_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // command
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire logic [1:0] cmd_kind,
    input wire logic [6:0] cmd_dev,
    input wire logic [7:0] cmd_sub,
    input wire logic [7:0] cmd_len,
    // data
    input wire logic [7:0] wr_data,
    output logic wr_take,
    output logic [7:0] rd_data,
    output logic rd_valid,
    output logic done,
    output logic nack_seen,
    // link
    hrp_link_if.host link
);
    // ----------------------------------------
    // states
    // ----------------------------------------
    typedef enum logic [4:0] {
        H_IDLE = 5'b00001,
        H_START = 5'b00010,
        H_TX = 5'b00100,
        H_RX = 5'b01000,
        H_STOP = 5'b10000
    } hrp_hst_t;

    hrp_hst_t st_q;
    logic [7:0] qcnt_q;          // ref_clk cycles within a quarter
    logic [1:0] ph_q;            // quarter within a bit
    logic [3:0] bit_q;           // bit within a byte
    logic [2:0] stg_q;           // which byte of the access
    logic [1:0] kind_q;
    logic [6:0] dev_q;
    logic [7:0] sub_q;
    logic [7:0] left_q;          // data bytes still to move
    logic [7:0] sh_q;
    logic ack_q;
    logic scl_oe_q, sda_oe_q;
    logic sda_s1_q, sda_s2_q;
    logic ready_q, take_q, rdv_q, done_q, nack_q;

    wire tick = (qcnt_q == QTR_LAST);
    wire last = (left_q == 8'h01);
    wire [7:0] addr_byte = {dev_q, stg_q == STG_ADDR_R}; // R09

    assign link.m_scl_o = 1'b0;
    assign link.m_sda_o = 1'b0;
    assign link.m_scl_oe = scl_oe_q;
    assign link.m_sda_oe = sda_oe_q;
    assign cmd_ready = ready_q;
    assign wr_take = take_q;
    assign rd_data = sh_q;
    assign rd_valid = rdv_q;
    assign done = done_q;
    assign nack_seen = nack_q;

    // ----------------------------------------
    // divider and data line synchroniser
    // ----------------------------------------
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst || st_q == H_IDLE || tick)
            qcnt_q <= QTR_RST;
        else
            qcnt_q <= qcnt_q + 8'h01;
    end

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            {sda_s1_q, sda_s2_q} <= 2'h3;
        else
            {sda_s1_q, sda_s2_q} <= {link.sda, sda_s1_q};
    end

    // ----------------------------------------
    // bit and byte sequencer
    // ----------------------------------------
    // each bit: set data, raise clock, sample, lower clock
    always_ff @(posedge ref_clk)
    begin
        take_q <= 1'b0;
        rdv_q <= 1'b0;
        done_q <= 1'b0;
        if (sys_rst)
        begin
            st_q <= H_IDLE;
            {ph_q, bit_q, stg_q, kind_q} <= 11'h000;
            {dev_q, sub_q, left_q, sh_q} <= 31'h00000000;
            {ack_q, scl_oe_q, sda_oe_q, nack_q} <= 4'h0;
            ready_q <= 1'b0;
        end
        else if (st_q == H_IDLE)
        begin
            ready_q <= ~cmd_valid | ~ready_q;
            if (cmd_valid && ready_q)
            begin
                st_q <= H_START; // R12
                kind_q <= cmd_kind;
                dev_q <= cmd_dev;
                sub_q <= cmd_sub;
                left_q <= cmd_len;
                nack_q <= 1'b0;
                ph_q <= 2'h0;
                // short read goes straight to the read address
                stg_q <= (cmd_kind == CMD_SHORT_READ) ? STG_ADDR_R : STG_ADDR_W;
                scl_oe_q <= 1'b1;
                sda_oe_q <= 1'b0;
            end
        end
        else if (tick)
        begin
            ph_q <= ph_q + 2'h1;
            unique case (st_q)
                H_START:
                begin
                    if (ph_q == 2'h0)
                        scl_oe_q <= 1'b0;
                    else if (ph_q == 2'h1)
                        sda_oe_q <= 1'b1; // R01
                    else if (ph_q == 2'h2)
                        scl_oe_q <= 1'b1;
                    else
                    begin
                        st_q <= H_TX;
                        bit_q <= BIT_FIRST;
                        sh_q <= addr_byte;
                        sda_oe_q <= ~addr_byte[7];
                    end
                end
                H_TX, H_RX:
                begin
                    if (ph_q == 2'h0)
                        scl_oe_q <= 1'b0;
                    else if (ph_q == 2'h1)
                    begin
                        if (bit_q == BIT_ACK)
                            ack_q <= ~sda_s2_q;
                        else if (st_q == H_RX)
                            sh_q <= {sh_q[6:0], sda_s2_q};
                    end
                    else if (ph_q == 2'h2)
                        scl_oe_q <= 1'b1;
                    else if (bit_q != BIT_ACK)
                    begin
                        bit_q <= bit_q + 4'h1;
                        if (st_q == H_RX)
                            // acknowledge all but the final byte
                            sda_oe_q <= (bit_q == BIT_LAST_DATA) & ~last; // R13 R08
                        else if (bit_q == BIT_LAST_DATA)
                            sda_oe_q <= 1'b0; // R07
                        else
                            sda_oe_q <= ~sh_q[3'(BIT_LAST_DATA - bit_q - 4'h1)];
                    end
                    else
                    begin
                        // ninth period over: pick the next byte
                        bit_q <= BIT_FIRST;
                        sda_oe_q <= 1'b0;
                        if (st_q == H_RX)
                        begin
                            rdv_q <= 1'b1;
                            left_q <= left_q - 8'h01;
                            if (last)
                            begin
                                st_q <= H_STOP;
                                sda_oe_q <= 1'b1;
                            end
                        end
                        else if (!ack_q)
                        begin
                            st_q <= H_STOP;
                            nack_q <= 1'b1;
                            sda_oe_q <= 1'b1;
                        end
                        else if (stg_q == STG_ADDR_W)
                        begin
                            stg_q <= STG_SUB;
                            sh_q <= sub_q;
                            sda_oe_q <= ~sub_q[7];
                        end
                        else if (stg_q == STG_ADDR_R)
                        begin
                            st_q <= H_RX;
                            stg_q <= STG_DATA_R;
                        end
                        else if (stg_q == STG_SUB && kind_q == CMD_RAND_READ)
                        begin
                            st_q <= H_START; // R13
                            stg_q <= STG_ADDR_R;
                        end
                        else if (stg_q == STG_DATA_W && last)
                        begin
                            st_q <= H_STOP;
                            sda_oe_q <= 1'b1;
                        end
                        else
                        begin
                            if (stg_q == STG_DATA_W)
                                left_q <= left_q - 8'h01;
                            stg_q <= STG_DATA_W;
                            take_q <= 1'b1;
                            sh_q <= wr_data;
                            sda_oe_q <= ~wr_data[7];
                        end
                    end
                end
                H_STOP:
                begin
                    if (ph_q == 2'h0)
                        scl_oe_q <= 1'b0;
                    else if (ph_q == 2'h1)
                        sda_oe_q <= 1'b0; // R02
                    else if (ph_q == 2'h3)
                    begin
                        st_q <= H_IDLE;
                        done_q <= 1'b1;
                        ready_q <= 1'b0;
                    end
                end
                H_IDLE:
                    st_q <= H_IDLE;
            endcase
        end
    end
endmodule : hrp_host_port
`default_nettype wire

// file: shared/hrp_link_if.sv
/*
 Two-wire display channel between host and device.
 Both lines are open drain with a pull-up; the level is resolved here.
*/
`timescale 1ns/1ps
`default_nettype none
interface hrp_link_if;
    // host drives clock and data, device drives data only
    logic m_scl_o;
    logic m_scl_oe;
    logic m_sda_o;
    logic m_sda_oe;
    logic s_sda_o;
    logic s_sda_oe;
    // resolved wire levels
    logic scl;
    logic sda;
    // a line is low when any enabled driver pulls it low
    assign scl = ~(m_scl_oe & ~m_scl_o);
    assign sda = ~((m_sda_oe & ~m_sda_o) | (s_sda_oe & ~s_sda_o));
    modport host (output m_scl_o, m_scl_oe, m_sda_o, m_sda_oe, input scl, sda);
    modport dev (output s_sda_o, s_sda_oe, input scl, sda);
endinterface : hrp_link_if
`default_nettype wire

// file: shared/hrp_pkg.sv
/*
 Constants shared by both ends of the display channel port.
 Assumes a 50 MHz ref_clk on the host end.
*/
`default_nettype none
package hrp_pkg;
    // ----------------------------------------
    // timing
    // ----------------------------------------
    localparam int CLK_NS = 20;      // ref_clk period
    localparam int BIT_NS = 10000;   // one serial bit, 100 kHz
    // quarter bit, rounded up
    localparam int QTR_CYC = (BIT_NS + 4 * CLK_NS - 1) / (4 * CLK_NS);
    localparam logic [7:0] QTR_LAST = 8'(QTR_CYC - 1);
    localparam logic [7:0] QTR_RST = 8'h00;
    // ----------------------------------------
    // byte framing
    // ----------------------------------------
    localparam logic [3:0] BIT_FIRST = 4'h0;
    localparam logic [3:0] BIT_LAST_DATA = 4'h7;
    localparam logic [3:0] BIT_ACK = 4'h8;   // ninth period
    localparam logic [3:0] BIT_END = 4'h9;
    // ----------------------------------------
    // addresses
    // ----------------------------------------
    localparam logic [6:0] ADDR7_SEL0 = 7'h3A;    // 0x74 / 0x75
    localparam logic [6:0] ADDR7_SEL1 = 7'h3B;    // 0x76 / 0x77
    localparam logic [7:0] SUB_LINK_INTEGRITY = 8'h08;
    localparam logic [7:0] BYTE_RST = 8'h00;
    // ----------------------------------------
    // host commands and byte stages
    // ----------------------------------------
    localparam logic [1:0] CMD_WRITE = 2'h0;
    localparam logic [1:0] CMD_RAND_READ = 2'h1;
    localparam logic [1:0] CMD_SHORT_READ = 2'h2;
    localparam logic [2:0] STG_ADDR_W = 3'h0;
    localparam logic [2:0] STG_SUB = 3'h1;
    localparam logic [2:0] STG_DATA_W = 3'h2;
    localparam logic [2:0] STG_ADDR_R = 3'h3;
    localparam logic [2:0] STG_DATA_R = 3'h4;
endpackage : hrp_pkg
`default_nettype wire

// file: testbench/hdcp_receiver_i2c_slave_port_tb.sv
/* bench: host and device ends joined by hrp_link_if; the bench holds the registers */
`timescale 1ns/1ps
`default_nettype none
module hdcp_receiver_i2c_slave_port_tb
    import hrp_pkg::*;
;
    typedef struct {logic [1:0] k; logic [7:0] s; logic [7:0] d;} hrp_row_t;
    // command kind, subaddress, first data byte written or expected
    hrp_row_t rows [3] = '{'{CMD_WRITE, 8'h08, 8'hA5}, '{CMD_RAND_READ, 8'h08, 8'hA5},
        '{CMD_SHORT_READ, 8'h40, 8'hA5}};
    logic ref_clk = 1'b0, link_clk = 1'b0, sys_rst = 1'b1, addr_sel = 1'b0, cmd_valid = 1'b0;
    logic cmd_ready, wr_take, rd_valid, done, nack_seen, reg_wr_stb, reg_rd_stb;
    logic [1:0] cmd_kind = CMD_WRITE;
    logic [6:0] cmd_dev = ADDR7_SEL0;
    logic [7:0] cmd_sub = BYTE_RST, cmd_len = 8'h01, wr_data = BYTE_RST, reg_rdata = BYTE_RST;
    logic [7:0] rd_data, reg_addr, reg_wdata;
    logic [7:0] mem [256];
    int n_errors = 0, comparisons = 0, cyc = 0;
    hrp_link_if lnk();
    hrp_host_port i_hrp_host_port (.ref_clk(ref_clk), .sys_rst(sys_rst), .cmd_valid(cmd_valid),
        .cmd_ready(cmd_ready), .cmd_kind(cmd_kind), .cmd_dev(cmd_dev), .cmd_sub(cmd_sub),
        .cmd_len(cmd_len), .wr_data(wr_data), .wr_take(wr_take), .rd_data(rd_data),
        .rd_valid(rd_valid), .done(done), .nack_seen(nack_seen), .link(lnk));
    hrp_dev_port i_hrp_dev_port (.link_clk(link_clk), .link(lnk), .ref_clk(ref_clk),
        .sys_rst(sys_rst), .addr_sel(addr_sel), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr_stb(reg_wr_stb), .reg_rd_stb(reg_rd_stb), .reg_rdata(reg_rdata));
    hrp_sva i_hrp_sva (.ref_clk(ref_clk), .sys_rst(sys_rst), .addr_sel(addr_sel),
        .scl(lnk.scl), .sda(lnk.sda), .m_sda_oe(lnk.m_sda_oe), .s_sda_oe(lnk.s_sda_oe));
    // link clock free running, phase unrelated to ref_clk
    initial forever #10 ref_clk = ~ref_clk;
    initial
    begin
        #7;
        forever #24 link_clk = ~link_clk;
    end
    // register file behind the device
    initial foreach (mem[i]) mem[i] = BYTE_RST;
    always @(posedge ref_clk) if (reg_wr_stb === 1'b1) mem[reg_addr] <= reg_wdata;
    always @(negedge ref_clk) reg_rdata <= mem[reg_addr];
    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        comparisons++;
        if (got !== exp)
        begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic end_sim();
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : end_sim
    // one access; read bytes must count up from d
    task automatic run(input logic [1:0] k, input logic [6:0] dv, input logic [7:0] s,
        input logic [7:0] d, input logic [7:0] n, input logic nk);
        int i;
        i = 0;
        while (cmd_ready !== 1'b1) @(negedge ref_clk);
        cmd_kind = k;
        cmd_dev = dv;
        cmd_sub = s;
        cmd_len = n;
        wr_data = d;
        cmd_valid = 1'b1;
        @(negedge ref_clk);
        cmd_valid = 1'b0;
        while (done !== 1'b1)
        begin
            @(negedge ref_clk);
            // next write byte after each take
            if (wr_take === 1'b1) wr_data = wr_data + 8'h01;
            if (rd_valid === 1'b1)
            begin
                chk("read byte", d + 8'(i), rd_data);
                i++;
            end
        end
        chk("read count", (k == CMD_WRITE || nk) ? 8'h00 : n, 8'(i));
        chk("no-ack flag", {7'h00, nk}, {7'h00, nack_seen});
    endtask : run
    initial
    begin
        repeat (12) @(negedge ref_clk);
        chk("ready in reset", 8'h00, {7'h00, cmd_ready});
        sys_rst = 1'b0;
        foreach (rows[r]) run(rows[r].k, ADDR7_SEL0, rows[r].s, rows[r].d, 8'h02, 1'b0);
        run(CMD_SHORT_READ, ADDR7_SEL1, BYTE_RST, BYTE_RST, 8'h01, 1'b1);
        addr_sel = 1'b1;
        repeat (4) @(negedge ref_clk);
        run(CMD_SHORT_READ, ADDR7_SEL1, BYTE_RST, 8'hA5, 8'h01, 1'b0);
        end_sim();
    end
    // hang guard, well above the roughly 73000 cycles of the run
    always @(posedge ref_clk)
    begin
        cyc++;
        if (cyc == 90000)
        begin
            n_errors++;
            end_sim();
        end
    end
endmodule : hdcp_receiver_i2c_slave_port_tb
`default_nettype wire

// file: testbench/hrp_sva.sv
/* wire checker for hrp_link_if; fed by the bench with the resolved lines */
`timescale 1ns/1ps
`default_nettype none
module hrp_sva
    import hrp_pkg::*;
(
    // clock, reset, base address choice
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic addr_sel,
    // line levels and data enables
    input wire logic scl,
    input wire logic sda,
    input wire logic m_sda_oe,
    input wire logic s_sda_oe
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    logic scl_q, sda_q, first_q, wr_q;
    logic [3:0] b_q;
    logic [7:0] sh_q;
    wire start_w = scl & sda_q & ~sda;
    wire stop_w = scl & ~sda_q & sda;
    wire rise_w = ~scl_q & scl;
    wire fall_w = scl_q & ~scl;
    wire ack_w = b_q == BIT_ACK;
    wire match_w = sh_q[7:1] == (addr_sel ? ADDR7_SEL1 : ADDR7_SEL0);
    // bit slot since the last start; the ack bit never enters the shifter
    always_ff @(posedge ref_clk)
    begin
        scl_q <= scl;
        sda_q <= sda;
        if (sys_rst || start_w)
        begin
            // the start's own clock fall wraps this to the first bit
            b_q <= 4'hF;
            first_q <= 1'b1;
        end
        else if (fall_w)
        begin
            b_q <= ack_w ? BIT_FIRST : b_q + 4'h1;
            first_q <= first_q & ~ack_w;
            wr_q <= (first_q & ack_w) ? ~sh_q[0] : wr_q;
        end
        if (rise_w && !ack_w)
            sh_q <= {sh_q[6:0], sda};
    end
    chk_start_clock: assert property (start_w |-> ##[100:300] !scl)
        else $error("clock did not fall after start");
    chk_stop_idle: assert property (stop_w |=> scl[*8])
        else $error("clock moved after stop");
    chk_bit_stable: assert property (rise_w |=> $stable(sda)[*8])
        else $error("data moved in clock high");
    chk_no_clash: assert property (!(scl && m_sda_oe && s_sda_oe))
        else $error("both ends drive data");
    chk_ack_slot: assert property ($rose(s_sda_oe) && first_q |-> ack_w)
        else $error("address ack outside ninth slot");
    chk_addr_ack: assert property (rise_w && first_q && ack_w |-> s_sda_oe == match_w)
        else $error("address ack wrong");
    chk_write_ack: assert property (rise_w && ack_w && !first_q && wr_q |-> s_sda_oe)
        else $error("write byte not acked");
    chk_ack_free: assert property (fall_w && first_q && ack_w && !sh_q[0] |-> ##[1:40] !s_sda_oe)
        else $error("ack not released");
    cover property (stop_w);
    cover property (rise_w && ack_w && first_q && s_sda_oe);
    cover property (rise_w && ack_w && !wr_q && !sda && !s_sda_oe);
endmodule : hrp_sva
`default_nettype wire
